// file: hdl/asf_pkg.sv
// Shared constants and types for the ADC serial frame block
package asf_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int unsigned CMD_BITS      = 16;
  localparam int unsigned RESULT_BITS   = 14;
  localparam int unsigned EDGE_CNT_W    = 6;
  localparam logic [5:0]  CMD_LAST_EDGE = 6'h0f;  // Count before the 16th fall
  localparam logic [5:0]  EDGE_CNT_MAX  = 6'h3f;
  localparam logic [1:0]  RESULT_PAD    = 2'h0;   // Two zero LSBs under the result
  localparam logic [15:0] INVALID_WORD  = 16'hffff;

  // ----------------------------------------------------------------
  // Command words
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_HOLD_PREVIOUS_MODE = 16'h0000;
  localparam logic [15:0] CMD_LOW_POWER_HOLD     = 16'h8200;
  localparam logic [15:0] CMD_FULL_SHUTDOWN      = 16'h8300;
  localparam logic [15:0] CMD_AUTO_SCAN          = 16'ha000;
  localparam logic [2:0]  CMD_SINGLE_PREFIX      = 3'h6;   // Bits 15:13 of c000h..dc00h
  localparam logic [9:0]  CMD_SINGLE_LOW         = 10'h000;

  // ----------------------------------------------------------------
  // Program registers
  // ----------------------------------------------------------------
  localparam int unsigned PREG_COUNT      = 16;
  localparam logic [6:0]  PREG_AUTO_SEQ   = 7'h01;
  localparam logic [7:0]  PREG_RESET_VAL  = 8'h00;
  localparam logic [7:0]  AUTO_SEQ_RESET  = 8'hff;

  // ----------------------------------------------------------------
  // Timing and buffering
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned STANDBY_WAKE_NS = 20000;
  localparam int unsigned WAKE_CYCLES     = (STANDBY_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CNT_W      = 12;
  localparam int unsigned FIFO_DEPTH      = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_IDLE                  = 3'b000,
    MODE_LOW_POWER_HOLD        = 3'b001,
    MODE_FULL_SHUTDOWN         = 3'b010,
    MODE_AUTO_SCAN             = 3'b011,
    MODE_SINGLE_CHANNEL_SELECT = 3'b100,
    MODE_REGISTER_PROGRAMMING  = 3'b101,
    MODE_INVALID               = 3'b110
  } asf_mode_t;

  typedef enum logic [2:0] {
    KIND_HOLD     = 3'b000,
    KIND_STANDBY  = 3'b001,
    KIND_SHUTDOWN = 3'b010,
    KIND_AUTO     = 3'b011,
    KIND_SINGLE   = 3'b100,
    KIND_REGISTER = 3'b101,
    KIND_OTHER    = 3'b110
  } asf_cmd_kind_t;

  typedef struct packed {
    logic [6:0] addr;
    logic       write;
    logic [7:0] data;
  } asf_reg_access_t;

  typedef struct packed {
    logic       strobe;
    logic [2:0] channel;
  } asf_sample_req_t;

endpackage

// file: hdl/asf_fifo.sv
// Result buffer between the converter and the output shift register
`timescale 1ns/1ps
`default_nettype none

module asf_fifo #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wrPtr;
  logic [PW:0]      rdPtr;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign inReady  = (wrPtr[PW] == rdPtr[PW]) || (wrPtr[PW-1:0] != rdPtr[PW-1:0]);
  assign outValid = (wrPtr != rdPtr);
  assign push     = ce && inValid && inReady;
  assign pop      = ce && outReady && outValid;
  assign outData  = store[rdPtr[PW-1:0]];

  // Storage has no reset; only written slots are ever read
  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[wrPtr[PW-1:0]] <= inData;
    end
  end

  // Pointers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// file: hdl/asf_serial_frame.sv
// Serial frame logic of a multichannel SAR converter: command, daisy output, modes
`timescale 1ns/1ps
`default_nettype none

module asf_serial_frame
  import asf_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  input  wire logic                   ce,
  input  wire logic                   csN,
  input  wire logic                   sclk,
  input  wire logic                   sdi,
  input  wire logic                   daisy,
  output logic                        sdo,
  output logic                        sdoOe,
  output var asf_sample_req_t         sampleReq,
  input  wire logic                   convValid,
  output logic                        convReady,
  input  wire logic [RESULT_BITS-1:0] convData,
  output logic      [2:0]             alarmChannel,
  output var asf_mode_t               mode,
  output logic                        referenceOn,
  output logic                        analogOn,
  output logic                        wakeSettling
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Sort a complete command word into its kind
  function automatic asf_cmd_kind_t classify(input logic [15:0] w);
    asf_cmd_kind_t k;
    k = KIND_OTHER;
    if (w == CMD_HOLD_PREVIOUS_MODE) begin
      k = KIND_HOLD;
    end else if (w == CMD_LOW_POWER_HOLD) begin
      k = KIND_STANDBY;
    end else if (w == CMD_FULL_SHUTDOWN) begin
      k = KIND_SHUTDOWN;
    end else if (w == CMD_AUTO_SCAN) begin
      k = KIND_AUTO;
    end else if (w[15:13] == CMD_SINGLE_PREFIX && w[9:0] == CMD_SINGLE_LOW) begin
      k = KIND_SINGLE;
    end else if (!w[15]) begin
      k = KIND_REGISTER;
    end
    return k;
  endfunction

  // Next enabled channel above cur, wrapping; cur itself if none enabled
  function automatic logic [2:0] nextScan(input logic [7:0] seq, input logic [2:0] cur);
    logic [2:0] n;
    logic [2:0] c;
    logic       hit;
    n   = cur;
    hit = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      c = 3'(int'(cur) + i);
      if (!hit && seq[c]) begin
        n   = c;
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] csSync;
  logic [1:0] sclkSync;
  logic [1:0] sdiSync;
  logic [1:0] daisySync;
  logic       csPrev;
  logic       sclkPrev;

  // Two flops per pin; only stage 1 feeds logic
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      csSync    <= 2'h3;
      sclkSync  <= 2'h0;
      sdiSync   <= 2'h0;
      daisySync <= 2'h0;
      csPrev    <= 1'b1;
      sclkPrev  <= 1'b0;
    end else if (ce) begin
      csSync    <= {csSync[0], csN};
      sclkSync  <= {sclkSync[0], sclk};
      sdiSync   <= {sdiSync[0], sdi};
      daisySync <= {daisySync[0], daisy};
      csPrev    <= csSync[1];
      sclkPrev  <= sclkSync[1];
    end
  end

  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  logic                  frameActive;
  logic [EDGE_CNT_W-1:0] edgeCount;
  logic [15:0]           cmdShift;
  logic [15:0]           latchedCmd;
  logic                  cmdComplete;
  logic                  csFall;
  logic                  csRise;
  logic                  sclkFall;
  logic                  cmdDone;
  logic [15:0]           cmdWord;
  asf_cmd_kind_t         doneKind;
  asf_cmd_kind_t         frameKind;
  asf_reg_access_t       doneAccess;

  assign csFall     = ce && csPrev && !csSync[1];
  assign csRise     = ce && !csPrev && csSync[1];
  assign sclkFall   = ce && frameActive && sclkPrev && !sclkSync[1];
  assign cmdDone    = sclkFall && (edgeCount == CMD_LAST_EDGE);
  assign cmdWord    = {cmdShift[14:0], sdiSync[1]};
  assign doneKind   = classify(cmdWord);
  assign frameKind  = classify(latchedCmd);
  assign doneAccess = asf_reg_access_t'(cmdWord);

  // Frame window and falling-edge count, saturating
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      frameActive <= 1'b0;
      edgeCount   <= '0;
    end else if (csFall) begin
      frameActive <= 1'b1;
      edgeCount   <= '0;
    end else if (csRise) begin
      frameActive <= 1'b0;
    end else if (sclkFall && edgeCount != EDGE_CNT_MAX) begin
      edgeCount <= edgeCount + 1'b1;
    end
  end

  // Command word capture over the first 16 falls
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmdShift    <= '0;
      latchedCmd  <= CMD_HOLD_PREVIOUS_MODE;
      cmdComplete <= 1'b0;
    end else if (csFall) begin
      cmdComplete <= 1'b0;
    end else if (sclkFall && edgeCount < EDGE_CNT_W'(CMD_BITS)) begin
      cmdShift <= cmdWord;
      if (cmdDone) begin
        latchedCmd  <= cmdWord;
        cmdComplete <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Program registers
  // ----------------------------------------------------------------
  logic [7:0] progReg [PREG_COUNT];
  logic       accessMapped;

  assign accessMapped = (doneAccess.addr < 7'(PREG_COUNT));

  // Writes land on fall 16; scan logic reads them only at chip-select edges
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < int'(PREG_COUNT); i++) begin
        progReg[i] <= (7'(i) == PREG_AUTO_SEQ) ? AUTO_SEQ_RESET : PREG_RESET_VAL;
      end
    end else if (cmdDone && doneKind == KIND_REGISTER && doneAccess.write && accessMapped) begin
      progReg[doneAccess.addr[3:0]] <= doneAccess.data;
    end
  end

  // ----------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------
  asf_mode_t  next_mode;
  logic [2:0] nextChannel;

  // Decision made at chip-select rise from the latched command
  always_comb begin
    next_mode = mode;
    if (!cmdComplete) begin
      next_mode = MODE_INVALID;
    end else begin
      case (frameKind)
        KIND_HOLD: begin
          if (mode == MODE_REGISTER_PROGRAMMING) begin
            next_mode = MODE_IDLE;
          end else begin
            next_mode = mode;
          end
        end
        KIND_STANDBY:  next_mode = MODE_LOW_POWER_HOLD;
        KIND_SHUTDOWN: next_mode = MODE_FULL_SHUTDOWN;
        KIND_AUTO:     next_mode = MODE_AUTO_SCAN;
        KIND_SINGLE:   next_mode = MODE_SINGLE_CHANNEL_SELECT;
        KIND_REGISTER: begin
          // Low-power modes keep running while their registers are touched
          if (mode == MODE_LOW_POWER_HOLD || mode == MODE_FULL_SHUTDOWN) begin
            next_mode = mode;
          end else begin
            next_mode = MODE_REGISTER_PROGRAMMING;
          end
        end
        default:       next_mode = mode;
      endcase
    end
  end

  // Mode register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode <= MODE_IDLE;
    end else if (csRise) begin
      mode <= next_mode;
    end
  end

  // Channel for the next chip-select fall
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      nextChannel <= 3'h0;
    end else if (csRise && cmdComplete && frameKind == KIND_AUTO) begin
      nextChannel <= nextScan(progReg[PREG_AUTO_SEQ[3:0]], 3'h7);  // Restarts at lowest
    end else if (csRise && cmdComplete && frameKind == KIND_SINGLE) begin
      nextChannel <= latchedCmd[12:10];
    end else if (csFall && mode == MODE_AUTO_SCAN) begin
      nextChannel <= nextScan(progReg[PREG_AUTO_SEQ[3:0]], nextChannel);
    end
  end

  // ----------------------------------------------------------------
  // Sampling and conversion hand-off
  // ----------------------------------------------------------------
  logic convThisFrame;
  logic converting;

  assign converting = (mode == MODE_AUTO_SCAN) || (mode == MODE_SINGLE_CHANNEL_SELECT);

  // Sample strobe and alarm channel; invalid state starts nothing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sampleReq     <= '0;
      alarmChannel  <= 3'h0;
      convThisFrame <= 1'b0;
    end else if (ce) begin
      sampleReq.strobe <= csFall && converting;
      if (csFall) begin
        convThisFrame <= converting;
        if (converting) begin
          sampleReq.channel <= nextChannel;
          alarmChannel      <= nextChannel;
        end
      end
    end
  end

  // Standby wake window; only informs the analog side, host does the waiting
  logic [WAKE_CNT_W-1:0] wakeCount;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wakeCount <= '0;
    end else if (csRise && mode == MODE_LOW_POWER_HOLD &&
                 (next_mode == MODE_AUTO_SCAN || next_mode == MODE_SINGLE_CHANNEL_SELECT)) begin
      wakeCount <= WAKE_CNT_W'(WAKE_CYCLES);
    end else if (ce && wakeCount != '0) begin
      wakeCount <= wakeCount - 1'b1;
    end
  end

  assign wakeSettling = (wakeCount != '0);
  assign referenceOn  = (mode != MODE_FULL_SHUTDOWN);
  assign analogOn     = converting;

  // ----------------------------------------------------------------
  // Result buffer and output shift register
  // ----------------------------------------------------------------
  logic                   resValid;
  logic                   resPop;
  logic [RESULT_BITS-1:0] resData;
  logic [15:0]            loadWord;
  logic [15:0]            outShift;

  assign resPop = cmdDone && convThisFrame;

  asf_fifo #(
    .WIDTH (RESULT_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_result_fifo (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .ce       (ce),
    .inValid  (convValid),
    .inReady  (convReady),
    .inData   (convData),
    .outValid (resValid),
    .outReady (resPop),
    .outData  (resData)
  );

  // Word presented at fall 16: register read, result, or invalid filler
  always_comb begin
    if (doneKind == KIND_REGISTER && !doneAccess.write) begin
      loadWord = accessMapped ? {progReg[doneAccess.addr[3:0]], 8'h00} : 16'h0000;
    end else if (convThisFrame && resValid) begin
      loadWord = {resData, RESULT_PAD};
    end else begin
      loadWord = INVALID_WORD;
    end
  end

  // Output path; the daisy pin's chain input supplies the trailing bits
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      outShift <= '0;
      sdo      <= 1'b0;
    end else if (csFall) begin
      sdo <= 1'b0;
    end else if (cmdDone) begin
      outShift <= loadWord;
      sdo      <= loadWord[15];
    end else if (sclkFall && edgeCount > CMD_LAST_EDGE) begin
      outShift <= {outShift[14:0], daisySync[1]};
      sdo      <= outShift[14];
    end
  end

  // Drive only inside a frame so a shared line has one talker
  assign sdoOe = frameActive;

endmodule

`default_nettype wire

// file: verification/asf_serial_frame_props.sv
// Port-level checks for the serial frame block
`timescale 1ns/1ps
`default_nettype none

module asf_serial_frame_props
  import asf_pkg::*;
(
  input wire logic            sys_clk,
  input wire logic            resetn,
  input wire logic            ce,
  input wire logic            csN,
  input wire logic            sdo,
  input wire logic            sdoOe,
  input wire asf_sample_req_t sampleReq,
  input wire logic [2:0]      alarmChannel,
  input wire asf_mode_t       mode,
  input wire logic            referenceOn,
  input wire logic            analogOn
);
  // ------------------------------------------------------------
  // Frame edges, seen a few clocks late through the synchroniser
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn || !ce);  // A frozen design makes no progress

  sequence open_s;
    $fell(csN) ##1 !csN;
  endsequence

  sequence close_s;
    $rose(csN) ##1 csN;
  endsequence

  // Output enable follows the select pin both ways
  oe_open_a:    assert property (open_s |-> ##[1:3] sdoOe) else $error("sdo enable late");
  oe_close_a:   assert property (close_s |-> ##[1:3] !sdoOe) else $error("sdo not released");
  oe_idle_a:    assert property (csN [*5] |-> !sdoOe) else $error("sdo driven while deselected");
  sdo_quiet_a:  assert property ($rose(sdoOe) |-> !sdo [*8]) else $error("sdo high in command phase");
  // Mode may only move once the select pin has been high for a while
  mode_rise_a:  assert property (!$stable(mode) |-> csN && $past(csN, 2)) else $error("mode moved in frame");
  ref_power_a:  assert property (referenceOn == (mode != MODE_FULL_SHUTDOWN)) else $error("reference power");
  analog_pw_a:  assert property (analogOn == (mode inside {MODE_AUTO_SCAN, MODE_SINGLE_CHANNEL_SELECT}))
                  else $error("analog power");
  // One sample pulse per frame, only in a converting mode
  strobe_gate_a: assert property (sampleReq.strobe |-> !csN && analogOn ##1 !sampleReq.strobe)
                   else $error("stray sample pulse");
  strobe_start_a: assert property (open_s ##0 analogOn |-> ##[1:4] sampleReq.strobe)
                    else $error("no sample at frame start");
  alarm_keep_a: assert property (mode == MODE_INVALID |-> $stable(alarmChannel)) else $error("alarm moved");
endmodule

bind asf_serial_frame asf_serial_frame_props asf_serial_frame_props_inst (
  .sys_clk, .resetn, .ce, .csN, .sdo, .sdoOe, .sampleReq, .alarmChannel, .mode, .referenceOn, .analogOn
);

`default_nettype wire

// file: verification/asf_host_model.sv
// Behavioural host controller running serial frames
`timescale 1ns/1ps
`default_nettype none

module asf_host_model (
  input  wire logic        sys_clk,
  input  wire logic        sdo,
  input  wire logic        sdoOe,
  output var  logic        csN,
  output var  logic        sclk,
  output var  logic        sdi,
  output var  logic        daisy,
  output var  logic [47:0] rxWord,
  output var  logic        done
);
  // A released line shows no friendly level: it flips every clock
  logic      lastLevel = 1'b0;
  wire logic lineIn = sdoOe ? sdo : ~lastLevel;

  always @(posedge sys_clk) lastLevel <= lineIn;

  // Serial clock idles high and stands still between frames
  initial begin
    csN = 1'b1;
    sclk = 1'b1;
    sdi = 1'b0;
    daisy = 1'b0;
    rxWord = '0;
    done = 1'b0;
  end

  // ------------------------------------------------------------
  // One frame; caller enters just after a rising clock edge
  // ------------------------------------------------------------
  task automatic run_frame(input logic [15:0] cmd, input int n, input logic [15:0] dw);
    int k;
    rxWord <= '0;
    csN    <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (k = 1; k <= n; k++) begin
      sclk  <= 1'b1;
      sdi   <= (k <= 16) ? cmd[16 - k] : 1'b0;
      daisy <= (k >= 17 && k <= 32) ? dw[32 - k] : 1'b0;
      repeat (6) @(posedge sys_clk);
      sclk   <= 1'b0;
      rxWord <= {rxWord[46:0], lineIn};
      repeat (6) @(posedge sys_clk);
    end
    sclk <= 1'b1;
    repeat (6) @(posedge sys_clk);
    csN <= 1'b1;
    repeat (8) @(posedge sys_clk);
    done <= 1'b1;
    @(posedge sys_clk);
    done <= 1'b0;
  endtask
endmodule

`default_nettype wire

// file: verification/asf_serial_frame_tb.sv
// Self-checking bench: host frames, converter feed, result scoreboard
`timescale 1ns/1ps
`default_nettype none

module asf_serial_frame_tb
  import asf_pkg::*;
;
  typedef struct packed {
    logic        chk;
    logic [47:0] val;
  } asf_note_t;

  logic                   sys_clk = 1'b0;
  logic                   resetn = 1'b0;
  logic                   convValid = 1'b0;
  logic                   ce = 1'b1;
  logic [RESULT_BITS-1:0] convData = '0;
  logic                   csN, sclk, sdi, daisy, sdo, sdoOe, convReady, referenceOn, analogOn;
  logic                   wakeSettling, hostDone;
  logic [2:0]             alarmChannel;
  logic [47:0]            rxWord;
  asf_sample_req_t        sampleReq;
  asf_mode_t              mode;
  asf_note_t              expQ[$];
  logic [RESULT_BITS-1:0] dataQ[$];
  int                     fail_count = 0;
  int                     n_compared = 0;
  int                     seed = 71;

  always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

  // Clock enable from the bench; one whole frame runs while frozen
  asf_serial_frame asf_serial_frame_inst (
    .sys_clk, .resetn, .ce, .csN, .sclk, .sdi, .daisy, .sdo, .sdoOe, .sampleReq, .convValid,
    .convReady, .convData, .alarmChannel, .mode, .referenceOn, .analogOn, .wakeSettling
  );

  asf_host_model asf_host_model_inst (
    .sys_clk, .sdo, .sdoOe, .csN, .sclk, .sdi, .daisy, .rxWord, .done(hostDone)
  );

  // ------------------------------------------------------------
  // Comparison, report and frame helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic mode_is(input asf_mode_t m);
    check("mode", 48'(m), 48'(mode));
  endtask

  // Expected read-back: sixteen quiet bits, then the word, then the chained word
  task automatic frame(input logic [15:0] cmd, input int n, input logic [15:0] dw, input logic chk,
                       input logic [15:0] word);
    asf_note_t note;
    note.chk = chk;
    note.val = (n == 48) ? {16'h0, word, dw} : (n == 32) ? {32'h0, word} : 48'h0;
    expQ.push_back(note);
    asf_host_model_inst.run_frame(cmd, n, dw);
  endtask

  // Scoreboard: oldest note against each finished frame
  always @(posedge sys_clk) begin
    asf_note_t note;
    if (hostDone === 1'b1) begin
      if (expQ.size() == 0) begin
        check("pending notes", 48'h1, 48'h0);
      end else begin
        note = expQ.pop_front();
        if (note.chk) check("frame bits", note.val, rxWord);
      end
    end
  end

  // Hang guard
  initial begin
    repeat (80000) @(posedge sys_clk);
    check("run time", 48'h0, 48'h1);
    tally_and_finish;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int                     i;
    int                     r;
    logic                   rdy;
    logic [RESULT_BITS-1:0] d;
    logic [2:0]             al;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    mode_is(MODE_IDLE);
    frame(16'h0000, 32, 16'h0, 1'b1, 16'hffff);
    mode_is(MODE_IDLE);
    frame(16'h0200, 32, 16'h0, 1'b1, 16'hff00);
    frame(16'h0ba5, 16, 16'h0, 1'b1, 16'h0);
    frame(16'h0000, 16, 16'h0, 1'b1, 16'h0);
    mode_is(MODE_IDLE);
    $display("test registers finished");
    // Abort mid-command: nothing runs, reads go bad
    frame(16'ha000, 8, 16'h0, 1'b1, 16'h0);
    mode_is(MODE_INVALID);
    al = alarmChannel;
    frame(16'h0000, 32, 16'h0, 1'b1, 16'hffff);
    check("alarm channel", 48'(al), 48'(alarmChannel));
    $display("test abort finished");
    frame(16'h8200, 32, 16'h0, 1'b1, 16'hffff);
    mode_is(MODE_LOW_POWER_HOLD);
    frame(16'h0a00, 32, 16'h0, 1'b1, 16'ha500);
    frame(16'h0000, 32, 16'h0, 1'b1, 16'hffff);
    frame(16'h8100, 16, 16'h0, 1'b1, 16'h0);
    mode_is(MODE_LOW_POWER_HOLD);
    $display("test standby finished");
    // Fill the result buffer until it refuses
    r = $random(seed);
    d = r[RESULT_BITS-1:0];
    convValid <= 1'b1;
    convData  <= d;
    for (i = 0; i < 40; i++) begin
      @(negedge sys_clk);
      rdy = convReady;
      @(posedge sys_clk);
      if (rdy !== 1'b1) break;
      dataQ.push_back(d);
      r = $random(seed);
      d = r[RESULT_BITS-1:0];
      convData <= d;
    end
    convValid <= 1'b0;
    check("buffer depth", 48'(FIFO_DEPTH), 48'(dataQ.size()));
    if (dataQ.size() != FIFO_DEPTH) tally_and_finish;
    // Leave standby into channel 5, then wait out the wake time
    frame(16'hd400, 32, 16'h0, 1'b1, 16'hffff);
    mode_is(MODE_SINGLE_CHANNEL_SELECT);
    check("wake settling", 48'h1, 48'(wakeSettling));
    repeat (WAKE_CYCLES + 50) @(posedge sys_clk);
    check("wake settling", 48'h0, 48'(wakeSettling));
    // Two-device chain frames drain the buffer
    for (i = 0; i < FIFO_DEPTH; i++) begin
      r = $random(seed);
      frame(16'h0000, 48, r[15:0], 1'b1, {dataQ.pop_front(), RESULT_PAD});
      check("sample channel", 48'h5, 48'(sampleReq.channel));
    end
    // Registers written before standby survive its exit
    frame(16'h0a00, 32, 16'h0, 1'b1, 16'ha500);
    $display("test chain finished");
    frame(16'h8300, 32, 16'h0, 1'b0, 16'h0);
    mode_is(MODE_FULL_SHUTDOWN);
    frame(16'h0000, 16, 16'h0, 1'b1, 16'h0);
    mode_is(MODE_FULL_SHUTDOWN);
    // Clock enable low: a whole scan command must go unseen
    ce <= 1'b0;
    frame(16'ha000, 16, 16'h0, 1'b0, 16'h0);
    ce <= 1'b1;
    mode_is(MODE_FULL_SHUTDOWN);
    frame(16'ha000, 32, 16'h0, 1'b0, 16'h0);
    frame(16'h0000, 32, 16'h0, 1'b0, 16'h0);
    mode_is(MODE_AUTO_SCAN);
    $display("test shutdown finished");
    // Let the scoreboard take the last note first
    @(posedge sys_clk);
    check("notes left", 48'h0, 48'(expQ.size()));
    tally_and_finish;
  end
endmodule

`default_nettype wire
